// ===== test/lrc_link_sva.sv
`timescale 1ns/1ps
//----------------------------------------
// Link controller port checker
//----------------------------------------
module lrc_link_sva
  import lrc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [lrc_pkg::ADDR_BITS-1:0] station_addr,
  input wire logic carrier_present,
  input wire logic collision_seen,
  input wire logic transmitting,
  input wire logic tx_bit,
  input wire logic client_send_request,
  input wire logic tx_bit_req,
  input wire logic tx_rewind,
  input wire logic tx_done,
  input lrc_pkg::lrc_tx_result_type tx_result,
  input wire logic rx_done,
  input wire logic [lrc_pkg::ADDR_BITS-1:0] rx_dst
);
  // One clock domain, sync reset
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  tx_done_pulse_a: assert property (tx_done |=> !tx_done)
    else $error("send done held past one bit time");
  rx_done_pulse_a: assert property (rx_done |=> !rx_done)
    else $error("receive done held past one bit time");
  tx_result_legal_a: assert property (tx_done |->
    ((tx_result == tx_result_success) == $past(tx_bit_req, 2)))
    else $error("send result does not match its ending");
  send_needs_req_a: assert property ($rose(transmitting) |->
    client_send_request) else $error("send began without request");
  done_while_req_a: assert property (tx_done |-> client_send_request)
    else $error("send ended after request dropped");
  jam_holds_line_a: assert property ($rose(collision_seen) |=>
    transmitting [*8]) else $error("no jam after collision");
  jam_pattern_a: assert property ($rose(collision_seen) |=> tx_bit ##1
    !tx_bit ##1 tx_bit) else $error("jam pattern not alternating");
  rewind_after_jam_a: assert property (tx_rewind |-> !transmitting)
    else $error("retry scheduled while still sending");
  close_on_drop_a: assert property (rx_done |->
    !$past(carrier_present)) else $error("frame closed with carrier up");
  addr_filter_a: assert property (rx_done |-> (rx_dst == station_addr ||
    rx_dst == '1)) else $error("frame for another station delivered");
  bit_fetch_gate_a: assert property (tx_bit_req |-> transmitting &&
    client_send_request) else $error("bit fetched outside a send");
endmodule

// ===== test/lrc_phy_model.sv
`timescale 1ns/1ps
//----------------------------------------
// Physical layer stand-in
//----------------------------------------
module lrc_phy_model (
  input wire logic mclk,
  input wire logic transmitting,
  output logic carrier_present,
  output logic rx_bit_valid,
  output logic rx_bit,
  output logic collision_seen
);
  int coll_left = 0; // Collisions still to inject
  int tx_cyc = 0; // Bit times into our send
  int coll_cnt = 0; // Collision bit times left
  initial
  begin
    carrier_present = 0;
    rx_bit_valid = 0;
    rx_bit = 0;
  end
  assign collision_seen = (coll_cnt != 0) && transmitting;
  always @(posedge mclk)
  begin
    tx_cyc <= transmitting ? tx_cyc + 1 : 0;
    if (coll_cnt != 0)
      coll_cnt <= coll_cnt - 1;
    else if (tx_cyc == 20 && coll_left > 0)
    begin
      coll_cnt <= 10;
      coll_left <= coll_left - 1;
    end
  end
  // Released data line toggles so stale bits never look valid
  always @(posedge mclk)
    if (!carrier_present)
      #1 rx_bit = ~rx_bit;
  // carrier first, then frame bits only, random stalls
  task automatic send_frame(input logic b [$]);
    @(posedge mclk);
    #1 carrier_present = 1;
    foreach (b[i])
    begin
      @(posedge mclk);
      #1;
      while ($urandom_range(3) == 0)
      begin
        rx_bit_valid = 0;
        rx_bit = ~rx_bit;
        @(posedge mclk);
        #1;
      end
      rx_bit_valid = 1;
      rx_bit = b[i];
    end
    // fetch pending at carrier drop is junk
    @(posedge mclk);
    #1 carrier_present = 0;
    rx_bit = ~rx_bit;
    @(posedge mclk);
    #1 rx_bit_valid = 0;
  endtask
endmodule

// ===== test/tb_csma_cd_link_receive_collision.sv
`timescale 1ns/1ps
//----------------------------------------
// Bench for the link controller
//----------------------------------------
module tb_csma_cd_link_receive_collision;
  import lrc_pkg::*;
  logic mclk = 0, rst = 1, rx_data_ready = 0, req_q = 0, stall = 0, ce = 1;
  logic client_send_request = 0, client_fetch_request = 0;
  logic [47:0] station_addr = 48'h0, rx_dst, rx_src;
  logic carrier_present, rx_bit_valid, rx_bit, collision_seen;
  logic transmitting, tx_bit, tx_bit_req, tx_rewind, tx_done, rx_done;
  logic rx_data_end, rx_data_valid, tx_frame_bit, tx_frame_last;
  lrc_tx_result_type tx_result;
  lrc_rx_result_type rx_result;
  logic [15:0] rx_type;
  logic [7:0] rx_data;
  logic tx_mem [0:255] = '{default: 1'b0}; // Client frame bits
  int tx_len = 1, tx_idx = 0, n_rew = 0, errors = 0, n_checks = 0;
  logic [8:0] gotq [$]; // Popped {end, data} words
  logic txq [$]; // Bits seen on the wire
  initial forever #10 mclk = ~mclk;
  // Short retry limits keep abort runs brief
  lrc_link #(.ATTEMPTS(4), .BO_LIMIT(2)) i_dut (
    .mclk(mclk), .rst(rst), .ce(ce), .station_addr(station_addr),
    .carrier_present(carrier_present), .rx_bit_valid(rx_bit_valid),
    .rx_bit(rx_bit), .collision_seen(collision_seen),
    .transmitting(transmitting), .tx_bit(tx_bit),
    .client_send_request(client_send_request),
    .tx_frame_bit(tx_frame_bit), .tx_frame_last(tx_frame_last),
    .tx_bit_req(tx_bit_req), .tx_rewind(tx_rewind), .tx_done(tx_done),
    .tx_result(tx_result), .client_fetch_request(client_fetch_request),
    .rx_done(rx_done), .rx_result(rx_result), .rx_dst(rx_dst),
    .rx_src(rx_src), .rx_type(rx_type), .rx_data(rx_data),
    .rx_data_end(rx_data_end), .rx_data_valid(rx_data_valid),
    .rx_data_ready(rx_data_ready));
  lrc_phy_model i_phy (.mclk(mclk), .transmitting(transmitting),
    .carrier_present(carrier_present), .rx_bit_valid(rx_bit_valid),
    .rx_bit(rx_bit), .collision_seen(collision_seen));
  // Client answers bit fetches combinationally
  assign tx_frame_bit = tx_mem[tx_idx[7:0]];
  assign tx_frame_last = (tx_idx == tx_len - 1);
  // Client side bookkeeping and random pop stalls
  always @(posedge mclk)
  begin
    req_q <= tx_bit_req;
    tx_idx <= tx_rewind ? 0 : tx_idx + int'(tx_bit_req);
    if (tx_rewind)
    begin
      txq = {};
      n_rew++;
    end
    else if (req_q)
      txq.push_back(tx_bit);
    if (rx_data_valid && rx_data_ready)
      gotq.push_back({rx_data_end, rx_data});
    #1 rx_data_ready = !stall && ($urandom_range(3) != 0);
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Check sequence register, one wire bit per step
  function automatic logic [31:0] crc_step(logic [31:0] c, logic b);
    crc_step = {c[30:0], 1'b0} ^ ((c[31] ^ b) ? CRC_POLY : 32'h0);
  endfunction
  // Mode 0 good, 1 corrupt check, 2 corrupt plus 3 stray bits
  task automatic rx_case(input logic [47:0] dst, input int nd, input int mode,
    input logic fetch, input logic exp_done, input lrc_rx_result_type res);
    logic [7:0] oct [$];
    logic bits [$];
    logic [31:0] c;
    logic [47:0] src;
    logic [15:0] typ;
    int k;
    src = {$urandom, $urandom};
    typ = 16'($urandom);
    gotq = {};
    for (k = 0; k < 14 + nd; k++)
      oct.push_back(k < 6 ? dst[8*k+:8] : k < 12 ? src[8*k-48+:8] :
        k < 14 ? typ[8*k-96+:8] : 8'($urandom));
    c = CRC_INIT;
    foreach (oct[i])
      for (k = 0; k < 8; k++)
      begin
        bits.push_back(oct[i][k]);
        c = crc_step(c, oct[i][k]);
      end
    for (k = 31; k >= 0; k--)
      bits.push_back(~c[k] ^ (mode != 0 && k == 0));
    if (mode == 2)
      repeat (3) bits.push_back(1'b1);
    stall = (res == rx_result_overrun);
    client_fetch_request = fetch;
    i_phy.send_frame(bits);
    for (k = 0; k < 8 && rx_done !== 1'b1; k++)
    begin
      @(posedge mclk);
      #1;
    end
    check(rx_done, exp_done);
    if (exp_done)
    begin
      check(rx_result, res);
      check(rx_dst, dst);
      check(rx_src, src);
      check(rx_type, typ);
    end
    stall = 0;
    for (k = 0; k < 300 && (gotq.size() == 0 || gotq[$][8] !== 1'b1); k++)
    begin
      @(posedge mclk);
      #1;
    end
    if (exp_done && res != rx_result_overrun)
    begin
      check(gotq.size(), nd + 1);
      foreach (gotq[i])
        check(gotq[i], i < nd ? {1'b0, oct[14+i]} : {1'b1, END_FILL});
    end
    else if (!exp_done)
      check(gotq.size(), 0);
    check(rx_data_valid, 1'b0);
  endtask
  task automatic tx_case(input int ncoll, input lrc_tx_result_type res);
    int k;
    tx_len = $urandom_range(64, 200);
    foreach (tx_mem[i])
      tx_mem[i] = 1'($urandom);
    tx_idx = 0;
    n_rew = 0;
    txq = {};
    i_phy.coll_left = ncoll;
    client_send_request = 1;
    for (k = 0; k < 30000 && tx_done !== 1'b1; k++)
    begin
      @(posedge mclk);
      // Freeze the block at random while off the wire
      #1 ce = transmitting || tx_rewind || tx_done ||
        ($urandom_range(3) != 0);
    end
    check(tx_done, 1'b1);
    if (tx_done !== 1'b1)
      final_report();
    check(tx_result, res);
    if (res == tx_result_success)
    begin
      check(n_rew, ncoll);
      check(txq.size(), tx_len);
      foreach (txq[i])
        check(txq[i], tx_mem[i]);
    end
    else
      check(n_rew, ncoll - 1);
    @(posedge mclk);
    #1 client_send_request = 0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // Main sequence: reset, receive cases, then send cases
  initial
  begin
    int k;
    k = $urandom(32'h96372b8d);
    station_addr = {$urandom, $urandom} & ~48'h1;
    repeat (10) @(posedge mclk);
    #1 rst = 0;
    repeat (3) rx_case(station_addr, $urandom_range(46, 60), 0, 1, 1,
      rx_result_good);
    rx_case('1, 46, 0, 1, 1, rx_result_good);
    rx_case(station_addr ^ 48'h100, 46, 0, 1, 0, rx_result_good);
    rx_case(station_addr, 46, 0, 0, 0, rx_result_good);
    rx_case(station_addr, 46, 1, 1, 1, rx_result_crc_bad);
    rx_case(station_addr, 47, 2, 1, 1, rx_result_misaligned);
    rx_case(station_addr, 0, 0, 1, 0, rx_result_good);
    rx_case(station_addr, 46, 0, 1, 1, rx_result_overrun);
    tx_case(0, tx_result_success);
    tx_case(2, tx_result_success);
    tx_case(4, tx_result_too_many_retries);
    final_report();
  end
endmodule
bind lrc_link lrc_link_sva i_sva (.mclk(mclk), .rst(rst),
  .station_addr(station_addr), .carrier_present(carrier_present),
  .collision_seen(collision_seen), .transmitting(transmitting),
  .tx_bit(tx_bit),
  .client_send_request(client_send_request), .tx_bit_req(tx_bit_req),
  .tx_rewind(tx_rewind), .tx_done(tx_done), .tx_result(tx_result),
  .rx_done(rx_done), .rx_dst(rx_dst));

// ===== verilog/lrc_fifo.sv
`timescale 1ns/1ps

// Push side of the receive buffer
interface lrc_stream_if #(
  parameter int unsigned W = 9
);
  logic valid;
  logic ready;
  logic flush;
  logic [W-1:0] data;
  modport src (output valid, output data, output flush, input ready);
  modport snk (input valid, input data, input flush, output ready);
endinterface

//----------------------------------------------------------------------
// Receive buffer with registered output word
//----------------------------------------------------------------------
module lrc_fifo #(
  parameter int unsigned W = 9,
  parameter int unsigned DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  lrc_stream_if.snk in_port,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  // Pointers wrap on power of two only
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1)
  begin : g_bad
    $error("lrc_fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic ov;
    logic [W-1:0] od;
  } lrc_fifo_state_type;

  lrc_fifo_state_type s_r;
  lrc_fifo_state_type s_nxt;
  logic push; // Word written this cycle
  logic pull; // Word moved to output register

  // Full is honest: ready drops at DEPTH stored words
  assign in_port.ready = (s_r.cnt != CW'(DEPTH));
  assign out_valid = s_r.ov;
  assign out_data = s_r.od;

  // Next state of storage and output stage
  always_comb
  begin
    s_nxt = s_r;
    push = in_port.valid && in_port.ready;
    pull = (s_r.cnt != '0) && (!s_r.ov || out_ready);
    if (s_r.ov && out_ready)
    begin
      s_nxt.ov = 1'b0;
    end
    if (pull)
    begin
      s_nxt.od = s_r.mem[s_r.rp];
      s_nxt.ov = 1'b1;
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_port.data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + CW'(push) - CW'(pull);
    // Flush empties storage and output register alike
    if (in_port.flush)
    begin
      s_nxt.ov = 1'b0;
      s_nxt.rp = '0;
      s_nxt.wp = '0;
      s_nxt.cnt = '0;
    end
  end

  // Registered state, frozen while ce is low
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end
endmodule

// ===== verilog/lrc_link.sv
`timescale 1ns/1ps

//----------------------------------------------------------------------
// Link controller: frame receive and transmit collision handling
//----------------------------------------------------------------------
module lrc_link #(
  parameter int unsigned SLOT = lrc_pkg::SLOT_BITS,
  parameter int unsigned JAM = lrc_pkg::JAM_BITS,
  parameter int unsigned ATTEMPTS = lrc_pkg::MAX_ATTEMPTS,
  parameter int unsigned BO_LIMIT = lrc_pkg::BACKOFF_LIMIT,
  parameter int unsigned DEPTH = lrc_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [lrc_pkg::ADDR_BITS-1:0] station_addr,
  input wire logic carrier_present,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic collision_seen,
  output logic transmitting,
  output logic tx_bit,
  input wire logic client_send_request,
  input wire logic tx_frame_bit,
  input wire logic tx_frame_last,
  output logic tx_bit_req,
  output logic tx_rewind,
  output logic tx_done,
  output lrc_pkg::lrc_tx_result_type tx_result,
  input wire logic client_fetch_request,
  output logic rx_done,
  output lrc_pkg::lrc_rx_result_type rx_result,
  output logic [lrc_pkg::ADDR_BITS-1:0] rx_dst,
  output logic [lrc_pkg::ADDR_BITS-1:0] rx_src,
  output logic [lrc_pkg::TYPE_BITS-1:0] rx_type,
  output logic [7:0] rx_data,
  output logic rx_data_end,
  output logic rx_data_valid,
  input wire logic rx_data_ready
);
  import lrc_pkg::*;

  //--------------------------------------------------------------------
  // Parameter checks
  //--------------------------------------------------------------------
  // slot covers round trip
  // Slot must cover the round trip or late collisions go unseen
  if (SLOT < ROUND_TRIP_BITS || SLOT >= 65536 || JAM < 1 ||
      JAM > 64 || ATTEMPTS < 2 || ATTEMPTS > 31 || BO_LIMIT < 1 ||
      BO_LIMIT > 10)
  begin : g_bad
    $error("lrc_link parameters out of range");
  end

  localparam logic [15:0] SLOT_LAST = 16'(SLOT - 1);
  localparam logic [5:0] JAM_LAST = 6'(JAM - 1);
  localparam logic [4:0] ATT_MAX = 5'(ATTEMPTS);
  localparam logic [4:0] BO_MAX = 5'(BO_LIMIT);

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  typedef struct packed {
    lrc_tx_state_type tx_st;
    logic [15:0] lfsr;     // Free running random source
    logic [4:0] att;       // Collisions seen on this frame
    logic [5:0] jam_cnt;   // Jam bits sent
    logic [9:0] slots;     // Backoff slots left
    logic [15:0] slot_bit; // Bit position inside a slot
    logic xmit;
    logic txb;
    logic rewind;
    logic tdone;
    lrc_tx_result_type tres;
    lrc_rx_state_type rx_st;
    logic [31:0] crc;
    logic [CNT_W-1:0] nbits;
    logic [HDR_BITS-1:0] hdr;
    logic [7:0] byte_sr;
    logic [31:0] dly;      // Holds back the check sequence octets
    logic [2:0] dly_n;
    logic addr_ok;
    logic overrun;
    logic rdone;
    lrc_rx_result_type rres;
    logic [ADDR_BITS-1:0] dst;
    logic [ADDR_BITS-1:0] src;
    logic [TYPE_BITS-1:0] typ;
  } lrc_state_type;

  lrc_state_type s_r;
  lrc_state_type s_nxt;
  lrc_state_type s_init;

  lrc_stream_if #(.W(FIFO_WIDTH)) push_if ();

  logic [HDR_BITS-1:0] hdr_new; // Header after this bit
  logic [7:0] byte_new;         // Octet after this bit
  logic take;                   // A frame bit is taken this cycle

  // Serial check sequence step, one bit
  function automatic logic [31:0] crc_step(
    input logic [31:0] c,
    input logic b
  );
    logic fb;
    fb = c[31] ^ b;
    return {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
  endfunction

  // Low k bits set, for the backoff range
  function automatic logic [9:0] range_mask(input logic [4:0] k);
    logic [9:0] m;
    m = '0;
    for (int i = 0; i < 10; i++)
    begin
      m[i] = (5'(i) < k);
    end
    return m;
  endfunction

  //--------------------------------------------------------------------
  // Reset image
  //--------------------------------------------------------------------
  always_comb
  begin
    s_init = '0;
    s_init.tx_st = TX_IDLE;
    s_init.rx_st = RX_IDLE;
    s_init.lfsr = LFSR_SEED;
    s_init.crc = CRC_INIT;
    s_init.tres = tx_result_success;
    s_init.rres = rx_result_good;
  end

  //--------------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    tx_bit_req = 1'b0;
    push_if.valid = 1'b0;
    push_if.data = '0;
    push_if.flush = 1'b0;
    s_nxt.tdone = 1'b0;
    s_nxt.rdone = 1'b0;
    s_nxt.rewind = 1'b0;
    // Galois shift every bit time, whatever else happens
    s_nxt.lfsr = {1'b0, s_r.lfsr[15:1]} ^
                 (s_r.lfsr[0] ? LFSR_TAPS : 16'h0000);

    // bits count only while carrier holds
    take = carrier_present && rx_bit_valid && (s_r.rx_st != RX_CLOSE);
    hdr_new = {rx_bit, s_r.hdr[HDR_BITS-1:1]};
    byte_new = {rx_bit, s_r.byte_sr[7:1]};

    if (take)
    begin
      s_nxt.crc = crc_step(s_r.crc, rx_bit);
      s_nxt.byte_sr = byte_new;
      if (s_r.nbits != '1)
      begin
        s_nxt.nbits = s_r.nbits + 1'b1;
      end
      if (s_r.nbits < CNT_W'(HDR_BITS))
      begin
        s_nxt.hdr = hdr_new;
      end
      // destination decided on its last bit
      if (s_r.nbits == CNT_W'(ADDR_BITS - 1))
      begin
        s_nxt.addr_ok = client_fetch_request &&
          ((hdr_new[HDR_BITS-1 -: ADDR_BITS] == station_addr) ||
           (hdr_new[HDR_BITS-1 -: ADDR_BITS] == '1));
      end
      // Data octets stream out four octets late, dropping the FCS
      if (s_r.nbits >= CNT_W'(HDR_BITS) && s_r.nbits[2:0] == 3'h7 &&
          s_r.addr_ok)
      begin
        s_nxt.dly = {byte_new, s_r.dly[31:8]};
        if (s_r.dly_n == 3'(FCS_OCTETS))
        begin
          push_if.valid = ce;
          push_if.data = {1'b0, s_r.dly[7:0]};
          // a full buffer is reported, not stalled on
          if (!push_if.ready)
          begin
            s_nxt.overrun = 1'b1;
          end
        end
        else
        begin
          s_nxt.dly_n = s_r.dly_n + 1'b1;
        end
      end
    end

    // Receive sequencer
    unique case (s_r.rx_st)
      RX_IDLE:
      begin
        if (carrier_present)
        begin
          s_nxt.rx_st = RX_COLLECT;
        end
      end
      RX_COLLECT:
      begin
        if (!carrier_present)
        begin
          s_nxt.rx_st = RX_CLOSE;
        end
      end
      RX_CLOSE:
      begin
        // short fragments vanish, buffered octets too
        if (s_r.addr_ok && s_r.nbits < CNT_W'(MIN_FRAME_BITS))
        begin
          push_if.flush = ce;
        end
        else if (s_r.addr_ok)
        begin
          // fields and status handed over together
          push_if.valid = ce;
          push_if.data = {1'b1, END_FILL};
          s_nxt.rdone = 1'b1;
          s_nxt.dst = s_r.hdr[DST_POS +: ADDR_BITS];
          s_nxt.src = s_r.hdr[SRC_POS +: ADDR_BITS];
          s_nxt.typ = s_r.hdr[TYPE_POS +: TYPE_BITS];
          // status from residue and octet boundary
          if (s_r.overrun || !push_if.ready)
          begin
            s_nxt.rres = rx_result_overrun;
          end
          else if (s_r.crc == CRC_RESIDUE)
          begin
            s_nxt.rres = rx_result_good;
          end
          else if (s_r.nbits[2:0] != 3'h0)
          begin
            s_nxt.rres = rx_result_misaligned;
          end
          else
          begin
            s_nxt.rres = rx_result_crc_bad;
          end
        end
        // Ready for the next frame
        s_nxt.crc = CRC_INIT;
        s_nxt.nbits = '0;
        s_nxt.dly_n = '0;
        s_nxt.addr_ok = 1'b0;
        s_nxt.overrun = 1'b0;
        s_nxt.rx_st = RX_IDLE;
      end
    endcase

    // Transmit sequencer
    unique case (s_r.tx_st)
      TX_IDLE:
      begin
        if (client_send_request)
        begin
          s_nxt.att = '0;
          s_nxt.tx_st = TX_DEFER;
        end
      end
      TX_DEFER:
      begin
        // Defer to passing traffic
        if (!carrier_present)
        begin
          s_nxt.tx_st = TX_START;
        end
      end
      TX_START:
      begin
        // flag up one bit time before the first bit
        s_nxt.xmit = 1'b1;
        s_nxt.tx_st = TX_SEND;
      end
      TX_SEND:
      begin
        // collision turns the send into a jam
        if (collision_seen)
        begin
          s_nxt.jam_cnt = '0;
          s_nxt.txb = 1'b1;
          s_nxt.tx_st = TX_JAM;
        end
        else
        begin
          tx_bit_req = ce;
          s_nxt.txb = tx_frame_bit;
          if (tx_frame_last)
          begin
            s_nxt.tx_st = TX_FINISH;
          end
        end
      end
      TX_FINISH:
      begin
        // flag drops after the last bit was shown
        s_nxt.xmit = 1'b0;
        s_nxt.txb = 1'b0;
        s_nxt.tres = tx_result_success;
        s_nxt.tdone = 1'b1;
        s_nxt.tx_st = TX_DONE;
      end
      TX_JAM:
      begin
        s_nxt.txb = ~s_r.txb;
        s_nxt.jam_cnt = s_r.jam_cnt + 1'b1;
        if (s_r.jam_cnt == JAM_LAST)
        begin
          // stop sending once jam is out
          s_nxt.xmit = 1'b0;
          s_nxt.txb = 1'b0;
          s_nxt.att = s_r.att + 1'b1;
          // give up after the attempt limit
          if (s_r.att + 1'b1 >= ATT_MAX)
          begin
            s_nxt.tres = tx_result_too_many_retries;
            s_nxt.tdone = 1'b1;
            s_nxt.tx_st = TX_DONE;
          end
          else
          begin
            s_nxt.slots = s_r.lfsr[9:0] & range_mask(
              (s_r.att + 1'b1 > BO_MAX) ? BO_MAX : s_r.att + 1'b1);
            s_nxt.slot_bit = '0;
            s_nxt.rewind = 1'b1;
            s_nxt.tx_st = TX_BACKOFF;
          end
        end
      end
      TX_BACKOFF:
      begin
        // wait the random number of slots, then retry
        if (s_r.slots == '0)
        begin
          s_nxt.tx_st = TX_DEFER;
        end
        else if (s_r.slot_bit == SLOT_LAST)
        begin
          s_nxt.slot_bit = '0;
          s_nxt.slots = s_r.slots - 1'b1;
        end
        else
        begin
          s_nxt.slot_bit = s_r.slot_bit + 1'b1;
        end
      end
      TX_DONE:
      begin
        // request released before the next one
        if (!client_send_request)
        begin
          s_nxt.tx_st = TX_IDLE;
        end
      end
    endcase
  end

  //--------------------------------------------------------------------
  // State register, frozen while ce is low
  //--------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_r <= s_init;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------
  assign transmitting = s_r.xmit;
  assign tx_bit = s_r.txb;
  assign tx_rewind = s_r.rewind;
  assign tx_done = s_r.tdone;
  assign tx_result = s_r.tres;
  assign rx_done = s_r.rdone;
  assign rx_result = s_r.rres;
  assign rx_dst = s_r.dst;
  assign rx_src = s_r.src;
  assign rx_type = s_r.typ;

  logic [FIFO_WIDTH-1:0] fifo_out; // End flag over octet

  // Data field octets, client drains at its own pace
  lrc_fifo #(
    .W(FIFO_WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .in_port(push_if),
    .out_valid(rx_data_valid),
    .out_data(fifo_out),
    .out_ready(rx_data_ready)
  );

  assign rx_data = fifo_out[7:0];
  assign rx_data_end = fifo_out[8];
endmodule

// ===== verilog/lrc_pkg.sv
//----------------------------------------------------------------------
// Contract
// - Accept every bit while carrier present holds
// - Carrier drop closes collected bits as frame
// - Deliver only frames addressed to this station
// - Status from check sequence and octet alignment
// - Collision during send triggers jam sequence
// - After jam, abort and retry at random time
// - Widen random backoff range on each retry; code widens only up to BO_LIMIT bits
// - Give up after too many collisions
// - Drop fragments shorter than minimum frame
// - Send request stays outstanding through all retries
// - Send result is success or too many retries
// - Fetch pends until frame, returns fields, status
// - Receive status good, crc bad, or misaligned
// - Extra result codes allowed on both sides
// - Round trip at most 450 bit times
// - Transmitting rises before first, falls after last
// - Discard bit pending when carrier falls
//----------------------------------------------------------------------
package lrc_pkg;

  // Bit timing: one enabled clock is one bit time
  localparam int unsigned BIT_TIME_NS = 100;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CLK_PER_BIT = BIT_TIME_NS / CLK_PERIOD_NS;

  // Channel timing in bit times, then attempt and backoff limits
  localparam int unsigned ROUND_TRIP_BITS = 450;
  localparam int unsigned SLOT_BITS = 512;
  localparam int unsigned JAM_BITS = 32;
  localparam int unsigned MAX_ATTEMPTS = 16;
  localparam int unsigned BACKOFF_LIMIT = 10;

  // Frame layout in bits, first bit of the frame at index 0
  localparam int unsigned ADDR_BITS = 48;
  localparam int unsigned TYPE_BITS = 16;
  localparam int unsigned HDR_BITS = 112;
  localparam int unsigned DST_POS = 0;
  localparam int unsigned SRC_POS = 48;
  localparam int unsigned TYPE_POS = 96;
  localparam int unsigned MIN_FRAME_BITS = 512;
  localparam int unsigned FCS_OCTETS = 4;
  localparam int unsigned CNT_W = 16;

  // Check sequence generator and good-frame residue
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hC704DD7B;

  // Receive buffer shape, then backoff random source seed and taps
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_WIDTH = 9;
  localparam logic [7:0] END_FILL = 8'h00;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;

  // Transmit sequencer, Gray along idle-defer-start-send-finish-done
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_DEFER = 3'b001,
    TX_START = 3'b011,
    TX_SEND = 3'b010,
    TX_FINISH = 3'b110,
    TX_DONE = 3'b111,
    TX_JAM = 3'b101,
    TX_BACKOFF = 3'b100
  } lrc_tx_state_type;

  // Receive sequencer, Gray along idle-collect-close
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_COLLECT = 2'b01,
    RX_CLOSE = 2'b11
  } lrc_rx_state_type;

  typedef enum logic [1:0] {
    tx_result_success = 2'h0,
    tx_result_too_many_retries = 2'h1
  } lrc_tx_result_type;

  // Overrun is an extra, implementation-specific outcome
  typedef enum logic [1:0] {
    rx_result_good = 2'h0,
    rx_result_crc_bad = 2'h1,
    rx_result_misaligned = 2'h2,
    rx_result_overrun = 2'h3
  } lrc_rx_result_type;

endpackage
